/* File: common/code_protect_consts.svh */
`ifndef CODE_PROTECT_CONSTS_SVH
`define CODE_PROTECT_CONSTS_SVH
// ==========================================================
// Address map
`define ADDR_W            22
`define BOOT_BYTES        512
`define BLK1_BASE         22'h001000
`define BLK2_BASE         22'h002000
`define BLK3_BASE         22'h003000
`define MEM_TOP           22'h003FFF
`define CFG_5L            22'h300008
`define CFG_5H            22'h300009
`define CFG_6L            22'h30000A
`define CFG_6H            22'h30000B
`define CFG_7L            22'h30000C
`define CFG_7H            22'h30000D
`define ID_FIRST          22'h200000
`define ID_LAST           22'h200007
`define DEVID_LO          22'h3FFFFE
`define DEVID_HI          22'h3FFFFF
// ==========================================================
// Field positions
`define BIT_EE_EXT        7
`define BIT_BOOT          6
`define BIT_CFG_WR        5
`define ERASED_BYTE       8'hFF
`endif

/* File: common/code_protect_pkg.sv */
package code_protect_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ERASE = 2'b01
    } erase_state_t;
    typedef logic [4:0] block_mask_t;
endpackage : code_protect_pkg

/* File: hdl/block_decode.sv */
`timescale 1ns/100ps
`include "code_protect_consts.svh"
// ==========================================================
// Address to protection block one-hot
module block_decode #(
    parameter int ADDR_W = `ADDR_W
) (
    input  wire logic [ADDR_W-1:0]          i_addr,
    output code_protect_pkg::block_mask_t   o_sel,
    output logic                            o_in_mem
);
    always_comb begin
        o_sel    = '0;
        o_in_mem = (i_addr <= ADDR_W'(`MEM_TOP));
        if (o_in_mem) begin
            if (i_addr < ADDR_W'(`BOOT_BYTES)) begin
                o_sel[4] = 1'b1;
            end else if (i_addr < ADDR_W'(`BLK1_BASE)) begin
                o_sel[0] = 1'b1;
            end else if (i_addr < ADDR_W'(`BLK2_BASE)) begin
                o_sel[1] = 1'b1;
            end else if (i_addr < ADDR_W'(`BLK3_BASE)) begin
                o_sel[2] = 1'b1;
            end else begin
                o_sel[3] = 1'b1;
            end
        end
    end
endmodule : block_decode

/* File: hdl/program_memory_code_protect.sv */
`timescale 1ns/100ps
`include "code_protect_consts.svh"
module program_memory_code_protect #(
    parameter int         ADDR_W      = `ADDR_W,
    parameter bit         LARGE_PART  = 1'b1,
    parameter logic [15:0] DEVICE_ID  = 16'h5A5A  // Arbitrary value
) (
    input  wire logic               i_sys_clk,
    input  wire logic               i_srst,
    // Table unit of the running program
    input  wire logic               i_tbl_rd,
    input  wire logic               i_tbl_wr,
    input  wire logic [ADDR_W-1:0]  i_tbl_addr,
    input  wire logic [ADDR_W-1:0]  i_pc_addr,
    input  wire logic [7:0]         i_tbl_wdata,
    input  wire logic [7:0]         i_mem_rdata,
    output logic                    o_tbl_rvalid,
    output logic [7:0]              o_tbl_rdata,
    output logic                    o_mem_wr,
    output logic [ADDR_W-1:0]       o_mem_addr,
    output logic [7:0]              o_mem_wdata,
    output logic                    o_tbl_wr_refused,
    // External programmer, already synchronised upstream by its own port logic
    input  wire logic               i_ext_mode,
    input  wire logic               i_ext_rd,
    input  wire logic               i_ext_wr,
    input  wire logic               i_ext_ee,
    input  wire logic [ADDR_W-1:0]  i_ext_addr,
    input  wire logic               i_ext_chip_erase,
    input  wire logic               i_ext_blk_erase,
    input  wire logic [4:0]         i_ext_erase_sel,
    output logic                    o_ext_rd_ok,
    output logic                    o_ext_wr_ok,
    output logic                    o_ext_ee_rd_ok,
    output logic                    o_ext_ee_wr_ok,
    // Processor side EEPROM request
    input  wire logic               i_cpu_ee_req,
    output logic                    o_cpu_ee_ok
);
    // Config, ID and device word all sit above the reach of narrower pointers
    if (ADDR_W < `ADDR_W) begin : g_addr_w_check
        $error("ADDR_W too small for config space");
    end

    logic [3:0]  ext_prot_q, wr_prot_q, xrd_prot_q;
    logic        boot_ext_q, boot_wr_q, boot_xrd_q;
    logic        ee_ext_q, ee_wr_q, cfg_wr_q;
    logic [7:0]  id_mem_q [0:7];
    code_protect_pkg::erase_state_t erase_st_q;

    code_protect_pkg::block_mask_t  tgt_sel, pc_sel, ext_sel;
    logic        tgt_mem, pc_mem, ext_mem;
    logic [4:0]  ext_bits, wr_bits, xrd_bits;
    logic [3:0]  upper_mask;

    // ==========================================================
    // Block decode of all three addresses
    block_decode #(.ADDR_W(ADDR_W)) u_dec_tgt (
        .i_addr   (i_tbl_addr),
        .o_sel    (tgt_sel),
        .o_in_mem (tgt_mem)
    );
    block_decode #(.ADDR_W(ADDR_W)) u_dec_pc (
        .i_addr   (i_pc_addr),
        .o_sel    (pc_sel),
        .o_in_mem (pc_mem)
    );
    block_decode #(.ADDR_W(ADDR_W)) u_dec_ext (
        .i_addr   (i_ext_addr),
        .o_sel    (ext_sel),
        .o_in_mem (ext_mem)
    );

    // Unimplemented upper bits on the small part always read one
    assign upper_mask = LARGE_PART ? 4'h0 : 4'hC;
    assign ext_bits = {boot_ext_q, ext_prot_q | upper_mask};
    assign wr_bits  = {boot_wr_q,  wr_prot_q  | upper_mask};
    assign xrd_bits = {boot_xrd_q, xrd_prot_q | upper_mask};

    // ==========================================================
    // Access decisions, straight from stored bits
    logic tgt_cfg, tgt_id, tgt_devid, tgt_allowed_wr, tgt_allowed_rd;
    logic [2:0] id_idx;
    logic [7:0] cfg_rd, rd_mux;
    assign tgt_cfg   = (i_tbl_addr >= ADDR_W'(`CFG_5L)) && (i_tbl_addr <= ADDR_W'(`CFG_7H));
    assign tgt_id    = (i_tbl_addr >= ADDR_W'(`ID_FIRST)) && (i_tbl_addr <= ADDR_W'(`ID_LAST));
    assign tgt_devid = (i_tbl_addr == ADDR_W'(`DEVID_LO)) || (i_tbl_addr == ADDR_W'(`DEVID_HI));
    assign id_idx    = i_tbl_addr[2:0];

    // Write guard: zero means protected
    assign tgt_allowed_wr = tgt_mem ? ((wr_bits & tgt_sel) == tgt_sel)
                          : tgt_cfg ? cfg_wr_q
                          : tgt_id;
    // Cross read allowed when bit set or reading own block
    assign tgt_allowed_rd = ((xrd_bits & tgt_sel) == tgt_sel) || (pc_mem && (pc_sel == tgt_sel));

    always_comb begin
        unique case (i_tbl_addr)
            ADDR_W'(`CFG_5L): cfg_rd = {4'h0, ext_bits[3:0]};
            ADDR_W'(`CFG_5H): cfg_rd = {ee_ext_q, boot_ext_q, 6'h00};
            ADDR_W'(`CFG_6L): cfg_rd = {4'h0, wr_bits[3:0]};
            ADDR_W'(`CFG_6H): cfg_rd = {ee_wr_q, boot_wr_q, cfg_wr_q, 5'h00};
            ADDR_W'(`CFG_7L): cfg_rd = {4'h0, xrd_bits[3:0]};
            ADDR_W'(`CFG_7H): cfg_rd = {1'b0, boot_xrd_q, 6'h00};
            default:          cfg_rd = 8'h00;
        endcase
    end

    always_comb begin
        rd_mux = 8'h00;
        if (tgt_mem) begin
            rd_mux = tgt_allowed_rd ? i_mem_rdata : 8'h00;
        end else if (tgt_cfg) begin
            rd_mux = cfg_rd;
        end else if (tgt_id) begin
            rd_mux = id_mem_q[id_idx];
        end else if (tgt_devid) begin
            rd_mux = i_tbl_addr[0] ? DEVICE_ID[15:8] : DEVICE_ID[7:0];
        end
    end

    // ==========================================================
    // Table read answer, one cycle after request
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_tbl_rvalid <= 1'b0;
            o_tbl_rdata  <= 8'h00;
        end else begin
            o_tbl_rvalid <= i_tbl_rd;
            o_tbl_rdata  <= i_tbl_rd ? rd_mux : 8'h00;
        end
    end

    // ==========================================================
    // Program memory write pass-through
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_mem_wr         <= 1'b0;
            o_mem_addr       <= '0;
            o_mem_wdata      <= 8'h00;
            o_tbl_wr_refused <= 1'b0;
        end else begin
            o_mem_wr         <= i_tbl_wr && tgt_mem && tgt_allowed_wr;
            o_mem_addr       <= i_tbl_addr;
            o_mem_wdata      <= i_tbl_wdata;
            o_tbl_wr_refused <= i_tbl_wr && !tgt_allowed_wr;
        end
    end

    // ==========================================================
    // ID bytes
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            for (int i = 0; i < 8; i++) begin
                id_mem_q[i] <= `ERASED_BYTE;
            end
        end else if (i_tbl_wr && tgt_id) begin
            id_mem_q[id_idx] <= i_tbl_wdata;
        end
    end

    // ==========================================================
    // Protection bits: clear by write, set only by external erase
    logic cfg_wr_go, erase_go;
    assign cfg_wr_go = i_tbl_wr && tgt_cfg && cfg_wr_q;
    // Erase accepted only in programming mode, never from the program
    // The cycle after an erase takes none, so a long pulse is not taken twice in a row
    assign erase_go  = i_ext_mode && (i_ext_chip_erase || i_ext_blk_erase)
                       && (erase_st_q == code_protect_pkg::ST_IDLE);

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            erase_st_q <= code_protect_pkg::ST_IDLE;
        end else begin
            unique case (erase_st_q)
                code_protect_pkg::ST_IDLE:
                    erase_st_q <= erase_go ? code_protect_pkg::ST_ERASE
                                           : code_protect_pkg::ST_IDLE;
                code_protect_pkg::ST_ERASE:
                    erase_st_q <= code_protect_pkg::ST_IDLE;
            endcase
        end
    end

    // Reset leaves nonvolatile bits alone; they model flash contents
    always_ff @(posedge i_sys_clk) begin
        if (erase_go && i_ext_chip_erase) begin
            ext_prot_q <= 4'hF;
            wr_prot_q  <= 4'hF;
            xrd_prot_q <= 4'hF;
            boot_ext_q <= 1'b1;
            boot_wr_q  <= 1'b1;
            boot_xrd_q <= 1'b1;
            ee_ext_q   <= 1'b1;
            ee_wr_q    <= 1'b1;
            cfg_wr_q   <= 1'b1;
        end else if (erase_go) begin
            ext_prot_q <= ext_prot_q | i_ext_erase_sel[3:0];
            wr_prot_q  <= wr_prot_q  | i_ext_erase_sel[3:0];
            xrd_prot_q <= xrd_prot_q | i_ext_erase_sel[3:0];
            boot_ext_q <= boot_ext_q | i_ext_erase_sel[4];
            boot_wr_q  <= boot_wr_q  | i_ext_erase_sel[4];
            boot_xrd_q <= boot_xrd_q | i_ext_erase_sel[4];
        end else if (cfg_wr_go) begin
            unique case (i_tbl_addr)
                ADDR_W'(`CFG_5L): ext_prot_q <= ext_prot_q & i_tbl_wdata[3:0];
                ADDR_W'(`CFG_5H): begin
                    ee_ext_q   <= ee_ext_q   & i_tbl_wdata[`BIT_EE_EXT];
                    boot_ext_q <= boot_ext_q & i_tbl_wdata[`BIT_BOOT];
                end
                ADDR_W'(`CFG_6L): wr_prot_q <= wr_prot_q & i_tbl_wdata[3:0];
                ADDR_W'(`CFG_6H): begin
                    ee_wr_q   <= ee_wr_q   & i_tbl_wdata[`BIT_EE_EXT];
                    boot_wr_q <= boot_wr_q & i_tbl_wdata[`BIT_BOOT];
                    // Program cannot touch the config guard itself
                    if (i_ext_mode) begin
                        cfg_wr_q <= cfg_wr_q & i_tbl_wdata[`BIT_CFG_WR];
                    end
                end
                ADDR_W'(`CFG_7L): xrd_prot_q <= xrd_prot_q & i_tbl_wdata[3:0];
                ADDR_W'(`CFG_7H): boot_xrd_q <= boot_xrd_q & i_tbl_wdata[`BIT_BOOT];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // External programmer and EEPROM gating
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_ext_rd_ok    <= 1'b0;
            o_ext_wr_ok    <= 1'b0;
            o_ext_ee_rd_ok <= 1'b0;
            o_ext_ee_wr_ok <= 1'b0;
            o_cpu_ee_ok    <= 1'b0;
        end else begin
            // Only the external path looks at external protect bits
            o_ext_rd_ok    <= i_ext_mode && i_ext_rd && !i_ext_ee
                              && (!ext_mem || ((ext_bits & ext_sel) == ext_sel));
            o_ext_wr_ok    <= i_ext_mode && i_ext_wr && !i_ext_ee
                              && (!ext_mem || ((ext_bits & ext_sel) == ext_sel));
            o_ext_ee_rd_ok <= i_ext_mode && i_ext_rd && i_ext_ee && ee_ext_q;
            o_ext_ee_wr_ok <= i_ext_mode && i_ext_wr && i_ext_ee && ee_ext_q && ee_wr_q;
            o_cpu_ee_ok    <= i_cpu_ee_req;
        end
    end
endmodule : program_memory_code_protect

/* File: tb/flash_model.sv */
`timescale 1ns/100ps
`include "code_protect_consts.svh"
// ==========================================================
// Program flash seen by the table unit
module flash_model #(
    parameter int ADDR_W = `ADDR_W
) (
    input  wire logic [ADDR_W-1:0] i_addr,
    output logic [7:0]             o_rdata
);
    // Address pattern, so a stale or shifted address shows as wrong data
    assign o_rdata = i_addr[7:0] ^ 8'hA5;
endmodule : flash_model

/* File: tb/code_protect_checker_asserts.sv */
`timescale 1ns/100ps
`include "code_protect_consts.svh"
// ==========================================================
// Port checker
module code_protect_checker #(
    parameter int ADDR_W = `ADDR_W
) (
    input wire logic              i_sys_clk,
    input wire logic              i_srst,
    input wire logic              i_tbl_rd,
    input wire logic              i_tbl_wr,
    input wire logic [ADDR_W-1:0] i_tbl_addr,
    input wire logic [7:0]        i_tbl_wdata,
    input wire logic              o_tbl_rvalid,
    input wire logic [7:0]        o_tbl_rdata,
    input wire logic              o_mem_wr,
    input wire logic [ADDR_W-1:0] o_mem_addr,
    input wire logic [7:0]        o_mem_wdata,
    input wire logic              o_tbl_wr_refused,
    input wire logic              i_ext_rd,
    input wire logic              i_ext_wr,
    input wire logic              i_ext_ee,
    input wire logic              o_ext_rd_ok,
    input wire logic              o_ext_ee_wr_ok,
    input wire logic              i_cpu_ee_req,
    input wire logic              o_cpu_ee_ok
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    logic in_gap;
    logic in_mem;
    assign in_gap = (i_tbl_addr > `MEM_TOP) && (i_tbl_addr < `ID_FIRST);
    assign in_mem = (i_tbl_addr <= `MEM_TOP);
    AST_RVALID: assert property (i_tbl_rd |=> o_tbl_rvalid)
        else $error("read got no valid");
    AST_RVALID_CAUSE: assert property (o_tbl_rvalid |-> $past(i_tbl_rd))
        else $error("valid without read");
    AST_WR_ANSWER: assert property (i_tbl_wr && in_mem |=> o_mem_wr ^ o_tbl_wr_refused)
        else $error("write not answered once");
    AST_WR_CAUSE: assert property ((o_mem_wr || o_tbl_wr_refused) |-> $past(i_tbl_wr))
        else $error("write answer without write");
    AST_WR_COPY: assert property (o_mem_wr |-> o_mem_addr == $past(i_tbl_addr)
        && o_mem_wdata == $past(i_tbl_wdata))
        else $error("flash write copy wrong");
    AST_GAP_RD: assert property (i_tbl_rd && in_gap |=> o_tbl_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_GAP_WR: assert property (i_tbl_wr && in_gap |=> o_tbl_wr_refused)
        else $error("unmapped write not refused");
    AST_CPU_EE: assert property (i_cpu_ee_req |=> o_cpu_ee_ok)
        else $error("cpu eeprom refused");
    AST_EE_WR_CAUSE: assert property (o_ext_ee_wr_ok |-> $past(i_ext_wr) && $past(i_ext_ee))
        else $error("eeprom grant without request");
    AST_EXT_RD_CAUSE: assert property (o_ext_rd_ok |-> $past(i_ext_rd))
        else $error("read grant without request");
    cover property (i_tbl_wr ##1 o_tbl_wr_refused);
    cover property (i_tbl_rd ##1 o_tbl_rdata == 8'h00);
    cover property (i_ext_rd ##1 !o_ext_rd_ok);
endmodule : code_protect_checker
bind program_memory_code_protect code_protect_checker #(.ADDR_W(ADDR_W)) u_chk (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_tbl_rd(i_tbl_rd), .i_tbl_wr(i_tbl_wr),
    .i_tbl_addr(i_tbl_addr), .i_tbl_wdata(i_tbl_wdata), .o_tbl_rvalid(o_tbl_rvalid),
    .o_tbl_rdata(o_tbl_rdata), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_tbl_wr_refused(o_tbl_wr_refused), .i_ext_rd(i_ext_rd),
    .i_ext_wr(i_ext_wr), .i_ext_ee(i_ext_ee), .o_ext_rd_ok(o_ext_rd_ok),
    .o_ext_ee_wr_ok(o_ext_ee_wr_ok), .i_cpu_ee_req(i_cpu_ee_req), .o_cpu_ee_ok(o_cpu_ee_ok));

/* File: tb/program_memory_code_protect_tb.sv */
`timescale 1ns/100ps
`include "code_protect_consts.svh"
module program_memory_code_protect_tb;
    localparam int AW = `ADDR_W;
    localparam logic [AW-1:0] PC0 = 22'h000400;
    localparam logic [AW-1:0] PC1 = 22'h001800;
    localparam logic [15:0]   DEV_WORD = 16'hC35A; // Arbitrary value
    logic          sys_clk = 1'h0, srst = 1'h1, tbl_rd = 1'h0, tbl_wr = 1'h0;
    logic [AW-1:0] tbl_addr = '0, pc_addr = '0, ext_addr = '0, mem_addr;
    logic [7:0]    wdata = 8'h00, mem_rdata, rdata, mem_wdata;
    logic          ext_mode = 1'h0, ext_rd = 1'h0, ext_wr = 1'h0, ext_ee = 1'h0;
    logic          chip_er = 1'h0, blk_er = 1'h0, ee_req = 1'h0, rvalid, mem_wr, refused;
    logic [4:0]    er_sel = 5'h00, ok;
    logic [7:0]    rdata_s;
    int            bad_count = 0, n_compared = 0;
    initial forever #2.5 sys_clk = ~sys_clk;
    flash_model #(.ADDR_W(AW)) u_flash (.i_addr(tbl_addr), .o_rdata(mem_rdata));
    program_memory_code_protect #(.DEVICE_ID(DEV_WORD)) u_dut (
        .i_sys_clk(sys_clk), .i_srst(srst), .i_tbl_rd(tbl_rd), .i_tbl_wr(tbl_wr),
        .i_tbl_addr(tbl_addr), .i_pc_addr(pc_addr), .i_tbl_wdata(wdata),
        .i_mem_rdata(mem_rdata), .o_tbl_rvalid(rvalid), .o_tbl_rdata(rdata),
        .o_mem_wr(mem_wr), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
        .o_tbl_wr_refused(refused), .i_ext_mode(ext_mode), .i_ext_rd(ext_rd),
        .i_ext_wr(ext_wr), .i_ext_ee(ext_ee), .i_ext_addr(ext_addr),
        .i_ext_chip_erase(chip_er), .i_ext_blk_erase(blk_er), .i_ext_erase_sel(er_sel),
        .o_ext_rd_ok(ok[4]), .o_ext_wr_ok(ok[3]), .o_ext_ee_rd_ok(ok[2]),
        .o_ext_ee_wr_ok(ok[1]), .i_cpu_ee_req(ee_req), .o_cpu_ee_ok(ok[0]));
    // Small variant beside it, so the forced upper block bits are seen
    program_memory_code_protect #(.LARGE_PART(1'b0), .DEVICE_ID(DEV_WORD)) u_small (
        .i_sys_clk(sys_clk), .i_srst(srst), .i_tbl_rd(tbl_rd), .i_tbl_wr(tbl_wr),
        .i_tbl_addr(tbl_addr), .i_pc_addr(pc_addr), .i_tbl_wdata(wdata),
        .i_mem_rdata(mem_rdata), .o_tbl_rvalid(), .o_tbl_rdata(rdata_s),
        .o_mem_wr(), .o_mem_addr(), .o_mem_wdata(), .o_tbl_wr_refused(),
        .i_ext_mode(ext_mode), .i_ext_rd(ext_rd), .i_ext_wr(ext_wr), .i_ext_ee(ext_ee),
        .i_ext_addr(ext_addr), .i_ext_chip_erase(chip_er), .i_ext_blk_erase(blk_er),
        .i_ext_erase_sel(er_sel), .o_ext_rd_ok(), .o_ext_wr_ok(), .o_ext_ee_rd_ok(),
        .o_ext_ee_wr_ok(), .i_cpu_ee_req(ee_req), .o_cpu_ee_ok());
    // ==========================================================
    // Tasks
    function automatic logic [7:0] pat(input logic [AW-1:0] a);
        return a[7:0] ^ 8'hA5;
    endfunction : pat
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rdc(input logic [AW-1:0] a, pc, input logic [7:0] m, exp);
        @(posedge sys_clk);
        tbl_rd   <= 1'h1;
        tbl_addr <= a;
        pc_addr  <= pc;
        @(posedge sys_clk);
        tbl_rd <= 1'h0;
        #1;
        chk("rvalid", 8'h01, {7'h00, rvalid});
        chk($sformatf("read %h", a), exp, rdata & m);
    endtask : rdc
    task automatic wrc(input logic [AW-1:0] a, input logic [7:0] d, input logic [1:0] m, exp);
        @(posedge sys_clk);
        tbl_wr   <= 1'h1;
        tbl_addr <= a;
        wdata    <= d;
        @(posedge sys_clk);
        tbl_wr <= 1'h0;
        #1;
        chk($sformatf("write %h", a), {6'h00, exp}, {6'h00, {mem_wr, refused} & m});
        if (exp[1]) begin
            chk("write data", d, mem_wdata);
            chk("write addr lo", a[7:0], mem_addr[7:0]);
            chk("write addr hi", a[15:8], mem_addr[15:8]);
        end
    endtask : wrc
    task automatic xc(input logic r, w, e, input logic [AW-1:0] a, input logic [4:0] m, exp);
        @(posedge sys_clk);
        ext_rd   <= r;
        ext_wr   <= w;
        ext_ee   <= e;
        ee_req   <= e;
        ext_addr <= a;
        @(posedge sys_clk);
        ext_rd <= 1'h0;
        ext_wr <= 1'h0;
        ee_req <= 1'h0;
        #1;
        chk($sformatf("grants %h", a), {3'h0, exp}, {3'h0, ok & m});
    endtask : xc
    task automatic mode(input logic m);
        @(posedge sys_clk);
        ext_mode <= m;
    endtask : mode
    task automatic erase(input logic chip, input logic [4:0] sel);
        @(posedge sys_clk);
        chip_er <= chip;
        blk_er  <= !chip;
        er_sel  <= sel;
        @(posedge sys_clk);
        chip_er <= 1'h0;
        blk_er  <= 1'h0;
    endtask : erase
    task automatic close_out();
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    // ==========================================================
    // Sequence
    initial begin
        #200000;
        bad_count++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        srst <= 1'h0;
        mode(1'h1);
        erase(1'h1, 5'h1F);
        mode(1'h0);
        rdc(`BLK1_BASE, PC0, 8'hFF, pat(`BLK1_BASE));
        rdc(`CFG_6H, PC0, 8'hE0, 8'hE0);
        rdc(`DEVID_LO, PC0, 8'hFF, DEV_WORD[7:0]);
        rdc(`DEVID_HI, PC0, 8'hFF, DEV_WORD[15:8]);
        wrc(22'h001004, 8'h3C, 2'h3, 2'h2);
        wrc(`CFG_6L, 8'hFD, 2'h1, 2'h0);
        wrc(22'h001004, 8'h3C, 2'h3, 2'h1);
        wrc(`BLK2_BASE, 8'h11, 2'h3, 2'h2);
        wrc(`CFG_6L, 8'hFF, 2'h1, 2'h0);
        wrc(22'h001FFF, 8'h3C, 2'h3, 2'h1);
        erase(1'h0, 5'h02);
        wrc(22'h001FFF, 8'h3C, 2'h3, 2'h1);
        wrc(`CFG_7L, 8'hFD, 2'h1, 2'h0);
        rdc(`BLK1_BASE, PC0, 8'hFF, 8'h00);
        rdc(`BLK1_BASE, PC1, 8'hFF, pat(`BLK1_BASE));
        rdc(22'h001FFF, `BLK2_BASE, 8'hFF, 8'h00);
        rdc(`CFG_7L, PC0, 8'h0F, 8'h0D);
        wrc(`ID_LAST, 8'h96, 2'h1, 2'h0);
        rdc(`ID_LAST, PC0, 8'hFF, 8'h96);
        rdc(`ID_FIRST, PC0, 8'hFF, 8'hFF);
        rdc(22'h004000, PC0, 8'hFF, 8'h00);
        wrc(22'h004000, 8'h55, 2'h3, 2'h1);
        wrc(`CFG_5L, 8'hFD, 2'h1, 2'h0);
        wrc(`CFG_5H, 8'h7F, 2'h1, 2'h0);
        rdc(`BLK1_BASE, PC1, 8'hFF, pat(`BLK1_BASE));
        mode(1'h1);
        xc(1'h1, 1'h0, 1'h0, `BLK1_BASE, 5'h10, 5'h00);
        xc(1'h1, 1'h0, 1'h0, `BLK2_BASE, 5'h10, 5'h10);
        xc(1'h0, 1'h1, 1'h0, `BLK1_BASE, 5'h08, 5'h00);
        xc(1'h0, 1'h1, 1'h0, `BLK2_BASE, 5'h08, 5'h08);
        xc(1'h1, 1'h0, 1'h1, 22'h000000, 5'h05, 5'h01);
        xc(1'h0, 1'h1, 1'h1, 22'h000000, 5'h03, 5'h01);
        mode(1'h0);
        wrc(`CFG_6H, 8'h1F, 2'h1, 2'h0);
        rdc(`CFG_6H, PC0, 8'hE0, 8'h20);
        wrc(22'h000010, 8'h01, 2'h3, 2'h1);
        mode(1'h1);
        wrc(`CFG_6H, 8'h1F, 2'h1, 2'h0);
        rdc(`CFG_6H, PC0, 8'hE0, 8'h00);
        wrc(`CFG_5L, 8'hFC, 2'h1, 2'h1);
        erase(1'h0, 5'h02);
        xc(1'h1, 1'h0, 1'h0, `BLK1_BASE, 5'h10, 5'h10);
        rdc(`BLK1_BASE, PC0, 8'hFF, pat(`BLK1_BASE));
        erase(1'h1, 5'h1F);
        xc(1'h0, 1'h1, 1'h1, 22'h000000, 5'h03, 5'h03);
        xc(1'h1, 1'h0, 1'h1, 22'h000000, 5'h05, 5'h05);
        wrc(`CFG_5L, 8'hFF, 2'h1, 2'h0);
        wrc(`CFG_7L, 8'hF0, 2'h1, 2'h0);
        rdc(`CFG_7L, PC0, 8'h0F, 8'h00);
        chk("small part cross bits", 8'h0C, rdata_s & 8'h0F);
        rdc(`BLK3_BASE, PC0, 8'hFF, 8'h00);
        chk("small part block 3", pat(`BLK3_BASE), rdata_s);
        close_out();
    end
endmodule : program_memory_code_protect_tb
